// ### design/cscp_pkg.sv
/*
  Constants for the chip settings command parser: byte positions of the
  set-settings report, field codes, response codes and reset values.
  Assumes a byte-serial report stream of 64 bytes, byte 0 first.
*/
package cscp_pkg;
  localparam int          CSCP_REPORT_LEN   = 64;
  localparam logic [7:0]  CSCP_CMD_SET      = 8'h21;
  localparam logic [7:0]  CSCP_RSP_OK       = 8'h00;
  localparam logic [7:0]  CSCP_RSP_DONTCARE = 8'h00;
  // Byte positions within a report
  localparam logic [5:0]  CSCP_POS_CODE     = 6'h00;
  localparam logic [5:0]  CSCP_POS_STATUS   = 6'h01;
  localparam logic [5:0]  CSCP_POS_FUNC0    = 6'h04;
  localparam logic [5:0]  CSCP_POS_FUNC8    = 6'h0c;
  localparam logic [5:0]  CSCP_POS_OUT_LO   = 6'h0d;
  localparam logic [5:0]  CSCP_POS_OUT_HI   = 6'h0e;
  localparam logic [5:0]  CSCP_POS_DIR_LO   = 6'h0f;
  localparam logic [5:0]  CSCP_POS_DIR_HI   = 6'h10;
  localparam logic [5:0]  CSCP_POS_OTHER    = 6'h11;
  localparam logic [5:0]  CSCP_POS_PROT     = 6'h12;
  localparam logic [5:0]  CSCP_POS_LAST     = 6'h3f;
  // Byte 17 fields
  localparam int          CSCP_BIT_WAKE     = 4;
  localparam int          CSCP_BIT_IMODE_LO = 1;
  localparam int          CSCP_BIT_HOLD     = 0;
  // Pin function codes
  localparam logic [7:0]  CSCP_FN_GPIO      = 8'h00;
  localparam logic [7:0]  CSCP_FN_CS        = 8'h01;
  localparam logic [7:0]  CSCP_FN_DEDIC     = 8'h02;
  // Interrupt counting codes
  localparam logic [2:0]  CSCP_IM_NONE      = 3'h0;
  localparam logic [2:0]  CSCP_IM_HIGH      = 3'h4;
  // Protection level codes
  localparam logic [7:0]  CSCP_PROT_NONE    = 8'h00;
  localparam logic [7:0]  CSCP_PROT_PASS    = 8'h40;
  localparam logic [7:0]  CSCP_PROT_LOCK    = 8'h80;
  // Reset values of the working configuration
  localparam logic [17:0] CSCP_RST_FUNC     = 18'h00000;
  localparam logic [7:0]  CSCP_RST_OUT      = 8'h00;
  localparam logic [7:0]  CSCP_RST_DIR      = 8'hff;
  localparam logic [2:0]  CSCP_RST_IMODE    = 3'h0;

  typedef enum logic [1:0] {CSCP_IDLE, CSCP_RECV, CSCP_SKIP, CSCP_RESP} cscp_state_type;
endpackage

// ### design/cscp_byte_decode.sv
/*
  Decodes one received command byte into a staged settings update.
  Combinational; assumes the caller presents the byte with its position.
*/
module cscp_byte_decode
  import cscp_pkg::*;
(
  input  wire logic [5:0]  pos_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [17:0] func_i,
  output logic      [17:0] func_o,
  output logic             func_bad_o
);
  logic [3:0] pin;
  logic [7:0] code;

  always_comb begin
    func_o     = func_i;
    func_bad_o = 1'b0;
    pin        = 4'h0;
    code       = data_i;
    if (pos_i >= CSCP_POS_FUNC0 && pos_i <= CSCP_POS_FUNC8) begin
      pin = 4'(pos_i - CSCP_POS_FUNC0);
      // The input-only pin never takes the chip select code
      if (code == CSCP_FN_GPIO || code == CSCP_FN_DEDIC ||
          (code == CSCP_FN_CS && pin != 4'h8)) begin // RL2
        func_o[2*pin +: 2] = code[1:0];
      end else begin
        func_bad_o = 1'b1;
      end
    end
  end
endmodule

// ### design/cscp_top.sv
/*
  Chip settings command parser: takes a 64-byte set-settings report as a
  byte stream, stages every field, applies them together on the last byte
  when no field is illegal and then streams back the 64-byte response report.
  Assumes the report source is on mclk_i and the response sink is always
  ready; non-volatile defaults live elsewhere and are never touched here.
*/
// What this block and its host do
// (RL1) Host sends code 0x21 in byte 0
// (RL2) Bytes 4-12 set functions; pin 8 never CS
// (RL3) Byte 13 gives default output levels
// (RL4) Byte 14 ignored completely
// (RL5) Byte 15 gives default directions
// (RL6) Host writes byte 16 bit 0 high
// (RL7) Byte 17 bit 4 enables remote wake-up
// (RL8) Byte 17 bits 3-1 choose interrupt counting
// (RL9) Byte 17 bit 0 holds SPI bus
// (RL10) Response byte 18 reports protection level
// (RL11) Host zero-fills bytes 18 to 63
// (RL12) Response echoes code, byte 1 is 0x00
// (RL13) Apply all fields at once, volatile only
module cscp_top
  import cscp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic [7:0]  prot_level_i,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o,
  output logic             rsp_last_o,
  output logic [17:0]      pin_func_o,
  output logic [7:0]       dflt_out_o,
  output logic [7:0]       dflt_dir_o,
  output logic             wake_en_o,
  output logic [2:0]       int_mode_o,
  output logic             bus_hold_o,
  output logic             applied_o,
  output logic             rejected_o
);
  typedef struct packed {
    cscp_state_type state;
    logic [5:0]     pos;
    logic [7:0]     code;
    logic [17:0]    s_func;
    logic [7:0]     s_out;
    logic [7:0]     s_dir;
    logic           s_wake;
    logic [2:0]     s_imode;
    logic           s_hold;
    logic           bad;
    logic [17:0]    func;
    logic [7:0]     dout;
    logic [7:0]     dir;
    logic           wake;
    logic [2:0]     imode;
    logic           hold;
    logic           applied;
    logic           rejected;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
    logic           rsp_last;
    logic [5:0]     rsp_pos;
  } cscp_regs_type;

  cscp_regs_type r;
  cscp_regs_type next_r;
  logic [17:0]   dec_func;
  logic          dec_bad;

  cscp_byte_decode u_dec (
    .pos_i      (r.pos),
    .data_i     (cmd_data_i),
    .func_i     (r.s_func),
    .func_o     (dec_func),
    .func_bad_o (dec_bad)
  );

  // ----------------------------------------------------------------
  // Response byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] cscp_rsp_byte(input logic [5:0] p, input logic [7:0] c,
                                               input logic [7:0] prot);
    if (p == CSCP_POS_CODE) begin
      return c; // RL12
    end else if (p == CSCP_POS_STATUS) begin
      return CSCP_RSP_OK; // RL12
    end else if (p == CSCP_POS_PROT) begin
      return prot; // RL10
    end else begin
      return CSCP_RSP_DONTCARE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Parser
  // ----------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.applied   = 1'b0;
    next_r.rejected  = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_last  = 1'b0;
    case (r.state)
      CSCP_IDLE, CSCP_RECV, CSCP_SKIP: begin
        if (cmd_valid_i) begin
          next_r.pos = r.pos + 6'h01;
          if (r.pos == CSCP_POS_CODE) begin
            next_r.code    = cmd_data_i;
            next_r.bad     = 1'b0;
            next_r.s_func  = r.func;
            next_r.s_out   = r.dout;
            next_r.s_dir   = r.dir;
            next_r.s_wake  = r.wake;
            next_r.s_imode = r.imode;
            next_r.s_hold  = r.hold;
            // Other commands belong to other handlers; drain them silently
            next_r.state = (cmd_data_i == CSCP_CMD_SET) ? CSCP_RECV : CSCP_SKIP; // RL1
          end else if (r.state == CSCP_RECV) begin
            next_r.s_func = dec_func;
            if (dec_bad) begin
              next_r.bad = 1'b1;
            end
            if (r.pos == CSCP_POS_OUT_LO) begin
              next_r.s_out = cmd_data_i; // RL3
            end else if (r.pos == CSCP_POS_OUT_HI) begin
              next_r.s_out = r.s_out; // RL4
            end else if (r.pos == CSCP_POS_DIR_LO) begin
              next_r.s_dir = cmd_data_i; // RL5
            end else if (r.pos == CSCP_POS_OTHER) begin
              next_r.s_wake  = cmd_data_i[CSCP_BIT_WAKE]; // RL7
              next_r.s_imode = cmd_data_i[CSCP_BIT_IMODE_LO +: 3]; // RL8
              next_r.s_hold  = cmd_data_i[CSCP_BIT_HOLD]; // RL9
              if (cmd_data_i[CSCP_BIT_IMODE_LO +: 3] > CSCP_IM_HIGH) begin
                next_r.bad = 1'b1;
              end
            end
          end
          if (r.pos == CSCP_POS_LAST) begin
            next_r.pos = 6'h00;
            if (r.state == CSCP_SKIP) begin
              next_r.state = CSCP_IDLE;
            end else if (r.bad) begin
              // Keep the old configuration rather than apply a partial one
              next_r.rejected = 1'b1;
              next_r.state    = CSCP_IDLE;
            end else begin
              // Volatile copy only; byte 16 content is not needed here
              next_r.func    = next_r.s_func; // RL13
              next_r.dout    = next_r.s_out; // RL13
              next_r.dir     = next_r.s_dir; // RL13
              next_r.wake    = next_r.s_wake; // RL13
              next_r.imode   = next_r.s_imode; // RL13
              next_r.hold    = next_r.s_hold; // RL13
              next_r.applied = 1'b1;
              next_r.rsp_pos = 6'h00;
              next_r.state   = CSCP_RESP;
            end
          end
        end
      end
      CSCP_RESP: begin
        next_r.rsp_valid = 1'b1;
        next_r.rsp_data  = cscp_rsp_byte(r.rsp_pos, r.code, prot_level_i);
        next_r.rsp_last  = (r.rsp_pos == CSCP_POS_LAST);
        next_r.rsp_pos   = r.rsp_pos + 6'h01;
        if (r.rsp_pos == CSCP_POS_LAST) begin
          next_r.state = CSCP_IDLE;
        end
      end
      default: next_r.state = CSCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      r       <= '0;
      r.state <= CSCP_IDLE;
      r.func  <= CSCP_RST_FUNC;
      r.dout  <= CSCP_RST_OUT;
      r.dir   <= CSCP_RST_DIR;
      r.imode <= CSCP_RST_IMODE;
    end else begin
      r <= next_r;
    end
  end

  assign rsp_valid_o = r.rsp_valid;
  assign rsp_data_o  = r.rsp_data;
  assign rsp_last_o  = r.rsp_last;
  assign pin_func_o  = r.func;
  assign dflt_out_o  = r.dout;
  assign dflt_dir_o  = r.dir;
  assign wake_en_o   = r.wake;
  assign int_mode_o  = r.imode;
  assign bus_hold_o  = r.hold;
  assign applied_o   = r.applied;
  assign rejected_o  = r.rejected;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_resp_head;
    rsp_valid_o && rsp_data_o == CSCP_CMD_SET ##1 rsp_valid_o && rsp_data_o == CSCP_RSP_OK;
  endsequence

  property p_resp_echo;
    @(posedge mclk_i) disable iff (reset_i) applied_o |-> ##1 s_resp_head;
  endproperty
  a_resp_echo: assert property (p_resp_echo) else $error("response head wrong"); // RL12

  property p_pin8_no_cs;
    @(posedge mclk_i) disable iff (reset_i) pin_func_o[17:16] != CSCP_FN_CS[1:0];
  endproperty
  a_pin8_no_cs: assert property (p_pin8_no_cs) else $error("pin 8 took chip select"); // RL2

  property p_imode_legal;
    @(posedge mclk_i) disable iff (reset_i) int_mode_o <= CSCP_IM_HIGH;
  endproperty
  a_imode_legal: assert property (p_imode_legal) else $error("reserved count mode applied"); // RL8

  property p_cfg_stable;
    @(posedge mclk_i) disable iff (reset_i)
      !applied_o |-> $stable({pin_func_o, dflt_out_o, dflt_dir_o, wake_en_o, int_mode_o, bus_hold_o});
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without apply"); // RL13

  property p_prot_byte;
    @(posedge mclk_i) disable iff (reset_i)
      applied_o |-> ##19 rsp_valid_o && rsp_data_o == $past(prot_level_i, 1);
  endproperty
  a_prot_byte: assert property (p_prot_byte) else $error("protection byte wrong"); // RL10

  property p_resp_len;
    @(posedge mclk_i) disable iff (reset_i) applied_o |-> ##64 rsp_last_o;
  endproperty
  a_resp_len: assert property (p_resp_len) else $error("response length wrong"); // RL12

  property p_out_lo;
    @(posedge mclk_i) disable iff (reset_i)
      (r.state == CSCP_RECV && cmd_valid_i && r.pos == CSCP_POS_OUT_LO)
        |=> r.s_out == $past(cmd_data_i);
  endproperty
  a_out_lo: assert property (p_out_lo) else $error("output byte not staged"); // RL3

  property p_dir_lo;
    @(posedge mclk_i) disable iff (reset_i)
      (r.state == CSCP_RECV && cmd_valid_i && r.pos == CSCP_POS_DIR_LO)
        |=> r.s_dir == $past(cmd_data_i);
  endproperty
  a_dir_lo: assert property (p_dir_lo) else $error("direction byte not staged"); // RL5

  property p_other;
    @(posedge mclk_i) disable iff (reset_i)
      (r.state == CSCP_RECV && cmd_valid_i && r.pos == CSCP_POS_OTHER)
        |=> r.s_wake == $past(cmd_data_i[4]) && r.s_hold == $past(cmd_data_i[0]);
  endproperty
  a_other: assert property (p_other) else $error("byte 17 not staged"); // RL7 RL9

  property p_hi_ignored;
    @(posedge mclk_i) disable iff (reset_i)
      (r.state == CSCP_RECV && cmd_valid_i && r.pos == CSCP_POS_OUT_HI) |=> $stable(r.s_out);
  endproperty
  a_hi_ignored: assert property (p_hi_ignored) else $error("byte 14 changed output"); // RL4
endmodule

// ### sim/cscp_host_model.sv
/*
  Host model: streams one 64-byte set-settings report into the parser.
  Assumes the bench holds rpt_i steady while busy_o is high.
*/
module cscp_host_model (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         send_i,
  input  wire logic [511:0] rpt_i,
  output logic              busy_o,
  output logic              cmd_valid_o,
  output logic [7:0]        cmd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] idx;
  logic [7:0] byte_now;

  // ----------------------------------------
  // Report shaping
  // ----------------------------------------
  always_comb begin
    byte_now = rpt_i[8*idx[5:0] +: 8];
    if (idx == 7'h10) begin
      byte_now[0] = 1'b1;
    end
    if (idx >= 7'h12) begin
      byte_now = 8'h00;
    end
  end

  // ----------------------------------------
  // Byte stream
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      busy_o      <= 1'b0;
      idx         <= 7'h00;
      cmd_valid_o <= 1'b0;
      cmd_data_o  <= 8'h5a;
    end else if (busy_o && idx < 7'h40) begin
      cmd_valid_o <= 1'b1;
      cmd_data_o  <= byte_now;
      idx         <= idx + 7'h01;
    end else begin
      // Idle data keeps toggling so a stale byte never looks valid
      cmd_valid_o <= 1'b0;
      cmd_data_o  <= ~cmd_data_o;
      busy_o      <= send_i;
      idx         <= 7'h00;
    end
  end
endmodule

// ### sim/test_cscp_top.sv
/*
  Self-checking bench for the chip settings command parser.
  Assumes the host model feeds reports and the response sink is always ready.
*/
module test_cscp_top
  import cscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i, reset_i, send, busy, cmd_valid_i, rsp_valid_o, rsp_last_o;
  logic wake_en_o, bus_hold_o, applied_o, rejected_o, e_wake, e_hold;
  logic [7:0] cmd_data_i, prot_level_i, rsp_data_o, dflt_out_o, dflt_dir_o, e_out, e_dir;
  logic [17:0] pin_func_o, e_func;
  logic [2:0] int_mode_o, e_mode;
  logic [38:0] cfg, cfg_prev;
  logic [511:0] rpt, r;
  logic [7:0] rq[$];
  logic [7:0] prots[3] = '{CSCP_PROT_NONE, CSCP_PROT_PASS, CSCP_PROT_LOCK};
  int unsigned cyc, n_app, n_rej, n_last, app_cyc, first_cyc, n_fail, total_checks;

  cscp_host_model host (.mclk_i(mclk_i), .reset_i(reset_i), .send_i(send), .rpt_i(rpt),
    .busy_o(busy), .cmd_valid_o(cmd_valid_i), .cmd_data_o(cmd_data_i));
  cscp_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_data_i(cmd_data_i), .prot_level_i(prot_level_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_last_o(rsp_last_o), .pin_func_o(pin_func_o),
    .dflt_out_o(dflt_out_o), .dflt_dir_o(dflt_dir_o), .wake_en_o(wake_en_o),
    .int_mode_o(int_mode_o), .bus_hold_o(bus_hold_o), .applied_o(applied_o),
    .rejected_o(rejected_o));

  assign cfg = {pin_func_o, dflt_out_o, dflt_dir_o, wake_en_o, int_mode_o, bus_hold_o};

  always #5 mclk_i = ~mclk_i;

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cfg();
    chk("pin_func", e_func, pin_func_o);
    chk("dflt_out", 18'(e_out), 18'(dflt_out_o));
    chk("dflt_dir", 18'(e_dir), 18'(dflt_dir_o));
    chk("wake_en", 18'(e_wake), 18'(wake_en_o));
    chk("int_mode", 18'(e_mode), 18'(int_mode_o));
    chk("bus_hold", 18'(e_hold), 18'(bus_hold_o));
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (!reset_i) begin
      if (applied_o === 1'b1) begin
        n_app++;
        app_cyc = cyc;
      end
      if (rejected_o === 1'b1) n_rej++;
      if (rsp_valid_o === 1'b1) begin
        if (rq.size() == 0) first_cyc = cyc;
        rq.push_back(rsp_data_o);
      end
      if (rsp_last_o === 1'b1) begin
        n_last++;
        chk("last_pos", 18'd64, 18'(rq.size()));
      end
      if (cfg !== cfg_prev) chk("cfg_apply", 18'd1, 18'(applied_o));
    end
    cfg_prev = cfg;
    if (cyc == 10000) begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [511:0] rnd_rpt(input logic [2:0] mode);
    logic [511:0] v;
    for (int i = 0; i < 16; i++) v[32*i +: 32] = $urandom;
    v[7:0] = CSCP_CMD_SET;
    for (int p = 0; p < 8; p++) v[8*(4+p) +: 8] = 8'($urandom_range(2));
    v[8*12 +: 8] = {6'h00, 1'($urandom_range(1)), 1'b0};
    v[8*17+1 +: 3] = mode;
    return v;
  endfunction

  // ----------------------------------------
  // One report and its expected outcome
  // ----------------------------------------
  task automatic run(input logic [511:0] v, input logic [7:0] prot);
    logic ok;
    logic set;
    set = (v[7:0] == CSCP_CMD_SET);
    ok = set && (v[8*17+1 +: 3] <= 3'h4) && (v[8*12 +: 8] != CSCP_FN_CS);
    for (int p = 0; p < 9; p++) if (v[8*(4+p) +: 8] > CSCP_FN_DEDIC) ok = 1'b0;
    rq.delete();
    n_app = 0;
    n_rej = 0;
    n_last = 0;
    @(posedge mclk_i);
    rpt <= v;
    send <= 1'b1;
    prot_level_i <= prot;
    @(posedge mclk_i);
    send <= 1'b0;
    repeat (140) @(posedge mclk_i);
    if (ok) begin
      for (int p = 0; p < 9; p++) e_func[2*p +: 2] = v[8*(4+p) +: 2];
      e_out = v[8*13 +: 8];
      e_dir = v[8*15 +: 8];
      {e_wake, e_mode, e_hold} = v[8*17 +: 5];
      chk("rsp_code", 18'(CSCP_CMD_SET), 18'(rq[0]));
      chk("rsp_status", 18'(CSCP_RSP_OK), 18'(rq[1]));
      chk("rsp_prot", 18'(prot), 18'(rq[18]));
      chk("rsp_delay", 18'd1, 18'(first_cyc - app_cyc));
    end
    chk("applied", 18'(ok), 18'(n_app));
    chk("rejected", 18'(set && !ok), 18'(n_rej));
    chk("rsp_count", ok ? 18'd64 : 18'd0, 18'(rq.size()));
    chk("rsp_last", 18'(ok), 18'(n_last));
    chk_cfg();
  endtask

  initial begin
    {mclk_i, send, rpt, prot_level_i, cyc, n_fail, total_checks} = '0;
    reset_i = 1'b1;
    {e_func, e_out, e_dir, e_wake, e_mode, e_hold} =
      {CSCP_RST_FUNC, CSCP_RST_OUT, CSCP_RST_DIR, 1'b0, CSCP_RST_IMODE, 1'b0};
    void'($urandom(32'h4bd8));
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk_cfg();
    for (int m = 0; m < 8; m++) run(rnd_rpt(3'(m)), prots[m % 3]);
    // All fields set, pin 8 as chip select, illegal code, foreign command
    r = rnd_rpt(3'h4);
    {r[8*17 +: 8], r[8*15 +: 8], r[8*13 +: 8]} = 24'hf9ffff;
    run(r, CSCP_PROT_PASS);
    r = rnd_rpt(3'h2);
    r[8*12 +: 8] = CSCP_FN_CS;
    run(r, CSCP_PROT_LOCK);
    r = rnd_rpt(3'h1);
    r[8*7 +: 8] = 8'h03;
    run(r, CSCP_PROT_NONE);
    r = rnd_rpt(3'h3);
    r[7:0] = 8'h33;
    run(r, CSCP_PROT_NONE);
    for (int i = 0; i < 20; i++) run(rnd_rpt(3'($urandom_range(4))), prots[$urandom_range(2)]);
    report_and_stop();
  end
endmodule
